// ---- cbt_defines.svh ----
// Offsets, field positions and codes of the chained breakpoint trace trigger
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

`define CBT_NSETS         8
`define CBT_MASTER_CTX    3'h0

// Register map, byte addresses
`define CBT_SET_AREA_BIT  7
`define CBT_REG_MODE      2'h0
`define CBT_REG_ADDR      2'h1
`define CBT_REG_DATA      2'h2
`define CBT_REG_MASK      2'h3
`define CBT_OFS_DBG_CTRL  8'h80
`define CBT_OFS_TR_CTRL   8'h84
`define CBT_OFS_TR_BASE   8'h88
`define CBT_OFS_STATUS    8'h8C

// Mode control fields
`define CBT_M_EN          15
`define CBT_M_RD          14
`define CBT_M_WR          13
`define CBT_M_CTXAW       12
`define CBT_M_CTX_HI      9
`define CBT_M_CTX_LO      7
`define CBT_M_WP          6
`define CBT_M_ACT_HI      5
`define CBT_M_ACT_LO      4
`define CBT_M_BSZ_HI      3
`define CBT_M_BSZ_LO      0
`define CBT_ACT_TRACE     2'h1
`define CBT_ACT_BRK       2'h2
`define CBT_ACT_CHAIN     2'h3

// Debug control fields
`define CBT_DC_BRK_NOP    0

// Trace control fields
`define CBT_TC_EN         15
`define CBT_TC_FULL       14
`define CBT_TC_TM_HI      11
`define CBT_TC_TM_LO      10
`define CBT_TC_BM_HI      7
`define CBT_TC_BM_LO      6
`define CBT_TC_SZ_HI      3
`define CBT_TC_SZ_LO      0
`define CBT_TC_WMASK      16'h8CCF
`define CBT_TM_CALL       2'h1
`define CBT_TM_BRANCH     2'h2
`define CBT_TM_DATA       2'h3
`define CBT_BM_SINGLE     2'h0
`define CBT_BM_CIRC       2'h1
`define CBT_BM_SIMPLE     2'h2
`define CBT_BUF_MIN       21'h000020
`define CBT_TR_STEP       21'h000004

`define CBT_EXC_VECTOR    8'h0C
`define CBT_RST_WORD      32'h00000000

`endif

// ---- cbt_pkg.sv ----
// Types of the chained breakpoint trace trigger
package cbt_pkg;

   // One CPU access presented for comparison
   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic        rd;
      logic        wr;
      logic [2:0]  ctx;
      logic [31:0] addr;
      logic [31:0] data;
   } cbt_acc_t;

   // Control transfer seen by the execution unit
   typedef struct packed {
      logic        valid;
      logic        is_call;
      logic        is_branch;
      logic [31:0] target;
   } cbt_flow_t;

   // Context switch notice
   typedef struct packed {
      logic       valid;
      logic [2:0] ctx;
   } cbt_csw_t;

   // Trace memory write
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic [31:0] data;
   } cbt_twr_t;

   // Breakpoint exception request
   typedef struct packed {
      logic       valid;
      logic [2:0] ctx;
      logic [7:0] vector;
   } cbt_exc_t;

   typedef struct packed {
      logic [7:0][15:0] mode;
      logic [7:0][31:0] addr;
      logic [7:0][31:0] data;
      logic [7:0][31:0] mask;
      logic [7:0]       armed;
      logic [31:0]      dbg_ctrl;
      logic [15:0]      tr_ctrl;
      logic [31:0]      tr_base;
      logic [20:0]      tr_ofs;
      logic [2:0]       trig_ctx;
      logic             ack;
      logic [31:0]      rdata;
      cbt_twr_t         twr;
      cbt_exc_t         exc;
   } cbt_state_t;

endpackage : cbt_pkg

// ---- cbt_trigger.sv ----
// Breakpoint/watchpoint matcher with chaining, trace writer and register slave
//
// Contract
// R1: Eight comparator sets of four registers; any set works alone.
// R2: Chains use consecutive set indices and may start at any set.
// R3: Chain links use chained mode; final set's trace or breakpoint mode ends it.
// R4: Chain fires only after all events matched in order; early repeats do nothing.
// R5: Final set in trace mode sets trace enable and starts recording.
// R6: Simple buffer mode raises exception 12 when buffer fills, not at trigger.
// R7: Final set in breakpoint mode raises exception 12 at its match.
// R8: Exception goes to the context of the matching access.
// R9: Debug control value 1 makes the software breakpoint a no-operation.
// R10: All-ones data mask demands exact data equality.
// R11: All-zero data mask matches any data at the address.
// R12: Breakpoint sets compare only the instruction address.
// R13: Software aligns trace base to buffer size.
// R14: Watchpoint covers 4 bytes or an aligned block, compared under mask.
// R15: Trace records switches into the master context.
// R16: Trace control 0x4485: disabled, full cleared, call, simple, 1 KB.
// R17: Trace control 0xC446: enabled, full cleared, call, circular, 2 KB.
// R18: Mode 0xD190: enabled read breakpoint, context 3, trace on fire.
// R19: Mode 0xC052: enabled 4-byte read watchpoint, any context, trace on fire.
// R20: Mode 0xB172: enabled chained 4-byte write watchpoint, context 2.
// R21: Full flag set on simple fill, cleared by master write of one; blocks trigger.
// R22: Simple mode stops and clears enable when full; no re-enable until cleared.
// R23: Circular mode wraps pointer to base and overwrites until disabled.
// R24: Per-chain progress advances only on next-in-order match, clears on fire.
`timescale 1ns/1ps
`include "cbt_defines.svh"

module cbt_trigger #(
   parameter int NSETS = `CBT_NSETS
) (
   input  wire logic               clk_sys_in,
   input  wire logic               rst_b_in,
   input  wire logic [7:0]         avs_address_in,
   input  wire logic               avs_read_in,
   input  wire logic               avs_write_in,
   input  wire logic [31:0]        avs_writedata_in,
   input  wire logic [3:0]         avs_byteenable_in,
   input  wire logic [2:0]         avs_ctx_in,
   output logic [31:0]             avs_readdata_out,
   output logic                    avs_waitrequest_out,
   input  wire cbt_pkg::cbt_acc_t  acc_in,
   input  wire cbt_pkg::cbt_flow_t flow_in,
   input  wire cbt_pkg::cbt_csw_t  csw_in,
   input  wire logic               sw_breakpoint_instruction_in,
   input  wire logic [2:0]         sw_breakpoint_ctx_in,
   output cbt_pkg::cbt_twr_t       trace_wr_out,
   output cbt_pkg::cbt_exc_t       exc_out,
   output logic                    trace_en_out,
   output logic                    trace_full_out
);
   import cbt_pkg::*;

   cbt_state_t       st_ff;
   cbt_state_t       nxt_st;
   logic [NSETS-1:0] match;
   logic [NSETS-1:0] chained;
   logic [NSETS-1:0] prev_chained;
   logic [NSETS-1:0] fire;
   logic [NSETS-1:0] wp_match;
   logic [31:0]      be_mask;
   logic [2:0]       wsel;
   logic [1:0]       wreg;
   logic             in_set_area;

   assign in_set_area = avs_address_in[`CBT_SET_AREA_BIT];
   assign wsel        = avs_address_in[6:4];
   assign wreg        = avs_address_in[3:2];
   assign be_mask     = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                         {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign prev_chained = {chained[NSETS-2:0], 1'b0};

   // Per-set comparators
   for (genvar g = 0; g < NSETS; g++)
   begin : g_set
      logic [15:0] md;
      logic [31:0] blk_mask;
      logic        ctx_ok;
      logic        bp_hit;
      logic        wp_hit;
      logic        dir_ok;
      assign md       = st_ff.mode[g];
      // Block of 2**size bytes; base must be aligned to it [R14]
      assign blk_mask = (32'h1 << md[`CBT_M_BSZ_HI:`CBT_M_BSZ_LO]) - 32'h1;
      assign ctx_ok   = !md[`CBT_M_CTXAW] ||
                        (acc_in.ctx == md[`CBT_M_CTX_HI:`CBT_M_CTX_LO]); // [R8]
      // Breakpoints ignore data, mask and block size [R12]
      assign bp_hit   = acc_in.fetch && (acc_in.addr == st_ff.addr[g]);
      assign dir_ok   = (acc_in.rd && md[`CBT_M_RD]) || (acc_in.wr && md[`CBT_M_WR]);
      // Masked data compare: ones demand equality, zeros ignore the bit [R10] [R11]
      assign wp_hit   = dir_ok && !acc_in.fetch &&
                        (((acc_in.addr ^ st_ff.addr[g]) & ~blk_mask) == 32'h0) && // [R14]
                        (((acc_in.data ^ st_ff.data[g]) & st_ff.mask[g]) == 32'h0);
      // Each set matches on its own [R1] [R18] [R19] [R20]
      assign match[g]    = acc_in.valid && md[`CBT_M_EN] && ctx_ok &&
                           (md[`CBT_M_WP] ? wp_hit : bp_hit);
      assign wp_match[g] = match[g] && md[`CBT_M_WP];
      assign chained[g]  = md[`CBT_M_EN] &&
                           (md[`CBT_M_ACT_HI:`CBT_M_ACT_LO] == `CBT_ACT_CHAIN); // [R3]
      // A set behind a chained neighbour counts only once armed [R2] [R4]
      assign fire[g]     = match[g] && (!prev_chained[g] || st_ff.armed[g]);
   end

   function automatic logic [31:0] rd_mux(input cbt_state_t s, input logic [7:0] a);
      logic [31:0] r;
      r = `CBT_RST_WORD;
      if (a[`CBT_SET_AREA_BIT] == 1'b0)
      begin
         unique case (a[3:2])
            `CBT_REG_MODE: r = {16'h0, s.mode[a[6:4]]};
            `CBT_REG_ADDR: r = s.addr[a[6:4]];
            `CBT_REG_DATA: r = s.data[a[6:4]];
            `CBT_REG_MASK: r = s.mask[a[6:4]];
         endcase
      end
      else if (a[7:2] == `CBT_OFS_DBG_CTRL >> 2)
         r = s.dbg_ctrl;
      else if (a[7:2] == `CBT_OFS_TR_CTRL >> 2)
         r = {16'h0, s.tr_ctrl};
      else if (a[7:2] == `CBT_OFS_TR_BASE >> 2)
         r = s.tr_base;
      else if (a[7:2] == `CBT_OFS_STATUS >> 2)
         r = {s.armed, 3'h0, s.tr_ofs};
      return r;
   endfunction : rd_mux

   always_comb
   begin
      logic        clr;
      logic        do_wr;
      logic        is_master;
      logic        trig_trace;
      logic        trig_brk;
      logic        rec;
      logic [31:0] rec_data;
      logic [20:0] buf_size;
      logic [20:0] ofs_next;
      logic [1:0]  act;
      clr        = 1'b0;
      do_wr      = avs_write_in && st_ff.ack;
      is_master  = (avs_ctx_in == `CBT_MASTER_CTX);
      trig_trace = 1'b0;
      trig_brk   = 1'b0;
      rec        = 1'b0;
      rec_data   = `CBT_RST_WORD;
      buf_size   = `CBT_BUF_MIN << st_ff.tr_ctrl[`CBT_TC_SZ_HI:`CBT_TC_SZ_LO];
      ofs_next   = st_ff.tr_ofs + `CBT_TR_STEP;
      act        = 2'h0;
      nxt_st     = st_ff;

      // One wait state: request seen, then answered on the next edge
      nxt_st.ack       = (avs_read_in || avs_write_in) && !st_ff.ack;
      nxt_st.rdata     = rd_mux(st_ff, avs_address_in);
      nxt_st.twr.valid = 1'b0;
      nxt_st.exc.valid = 1'b0;
      nxt_st.exc.vector = `CBT_EXC_VECTOR;

      if (do_wr)
      begin
         if (!in_set_area)
         begin
            unique case (wreg)
               `CBT_REG_MODE: nxt_st.mode[wsel] =
                  (st_ff.mode[wsel] & ~be_mask[15:0]) | (avs_writedata_in[15:0] & be_mask[15:0]);
               `CBT_REG_ADDR: nxt_st.addr[wsel] =
                  (st_ff.addr[wsel] & ~be_mask) | (avs_writedata_in & be_mask);
               `CBT_REG_DATA: nxt_st.data[wsel] =
                  (st_ff.data[wsel] & ~be_mask) | (avs_writedata_in & be_mask);
               `CBT_REG_MASK: nxt_st.mask[wsel] =
                  (st_ff.mask[wsel] & ~be_mask) | (avs_writedata_in & be_mask);
            endcase
            // Reprogramming a set drops any progress through it
            nxt_st.armed[wsel] = 1'b0;
         end
         else if (avs_address_in[7:2] == `CBT_OFS_DBG_CTRL >> 2)
            nxt_st.dbg_ctrl = (st_ff.dbg_ctrl & ~be_mask) | (avs_writedata_in & be_mask);
         else if (is_master && avs_address_in[7:2] == `CBT_OFS_TR_CTRL >> 2 &&
                  avs_byteenable_in[1:0] == 2'h3)
         begin
            // Full is write-one-to-clear; the other fields store [R16] [R17] [R21]
            nxt_st.tr_ctrl = (st_ff.tr_ctrl & ~`CBT_TC_WMASK) |
                             (avs_writedata_in[15:0] & `CBT_TC_WMASK);
            if (avs_writedata_in[`CBT_TC_FULL])
               nxt_st.tr_ctrl[`CBT_TC_FULL] = 1'b0;
            // A full simple buffer stays closed unless the same write clears full [R22]
            if (st_ff.tr_ctrl[`CBT_TC_FULL] && !avs_writedata_in[`CBT_TC_FULL])
               nxt_st.tr_ctrl[`CBT_TC_EN] = 1'b0;
            nxt_st.tr_ofs = 21'h0;
         end
         else if (is_master && avs_address_in[7:2] == `CBT_OFS_TR_BASE >> 2)
            nxt_st.tr_base = (st_ff.tr_base & ~be_mask) | (avs_writedata_in & be_mask);
      end

      // Chain progress: advance one link per in-order match [R24]
      for (int i = 0; i < NSETS; i++)
      begin
         if (fire[i] && prev_chained[i])
            nxt_st.armed[i] = 1'b0;
      end
      for (int i = 0; i < NSETS - 1; i++)
      begin
         if (fire[i] && chained[i])
            nxt_st.armed[i+1] = 1'b1; // [R4]
      end

      // Final sets end the chain; walking down clears its progress [R3] [R24]
      for (int i = NSETS - 1; i >= 0; i--)
      begin
         act = st_ff.mode[i][`CBT_M_ACT_HI:`CBT_M_ACT_LO];
         if (fire[i] && act == `CBT_ACT_TRACE)
         begin
            trig_trace = 1'b1;
            clr        = 1'b1;
         end
         if (fire[i] && act == `CBT_ACT_BRK)
         begin
            trig_brk  = 1'b1;
            clr       = 1'b1;
         end
         if (clr)
            nxt_st.armed[i] = 1'b0;
         if (!prev_chained[i])
            clr = 1'b0;
      end

      // Software breakpoint, unless made a no-operation [R9]
      if (sw_breakpoint_instruction_in && !st_ff.dbg_ctrl[`CBT_DC_BRK_NOP])
      begin
         nxt_st.exc.valid = 1'b1;
         nxt_st.exc.ctx   = sw_breakpoint_ctx_in;
      end
      // Breakpoint-mode chain end raises the exception at once [R7] [R8]
      if (trig_brk)
      begin
         nxt_st.exc.valid = 1'b1;
         nxt_st.exc.ctx   = acc_in.ctx;
      end
      // Trace-mode chain end starts tracing unless the buffer is full [R5] [R21]
      if (trig_trace && !st_ff.tr_ctrl[`CBT_TC_FULL])
      begin
         nxt_st.tr_ctrl[`CBT_TC_EN] = 1'b1;
         nxt_st.trig_ctx            = acc_in.ctx;
         if (!st_ff.tr_ctrl[`CBT_TC_EN])
            nxt_st.tr_ofs = 21'h0;
      end

      // Trace recording; context switches always go in, so a switch to the
      // master context marks the trigger point in a circular buffer [R15]
      if (st_ff.tr_ctrl[`CBT_TC_EN])
      begin
         if (csw_in.valid)
         begin
            rec      = 1'b1;
            rec_data = {29'h0, csw_in.ctx};
         end
         else
         begin
            unique case (st_ff.tr_ctrl[`CBT_TC_TM_HI:`CBT_TC_TM_LO])
               `CBT_TM_CALL:
               begin
                  rec      = flow_in.valid && flow_in.is_call;
                  rec_data = flow_in.target;
               end
               `CBT_TM_BRANCH:
               begin
                  rec      = flow_in.valid && (flow_in.is_call || flow_in.is_branch);
                  rec_data = flow_in.target;
               end
               `CBT_TM_DATA:
               begin
                  rec      = |wp_match;
                  rec_data = acc_in.data;
               end
               default:
               begin
                  rec      = 1'b0;
                  rec_data = `CBT_RST_WORD;
               end
            endcase
         end
      end

      if (rec)
      begin
         nxt_st.twr.valid = 1'b1;
         nxt_st.twr.data  = rec_data;
         // Base is assumed aligned to the buffer size, so OR forms the address [R13]
         if (st_ff.tr_ctrl[`CBT_TC_BM_HI:`CBT_TC_BM_LO] == `CBT_BM_SINGLE)
            nxt_st.twr.addr = st_ff.tr_base;
         else
         begin
            nxt_st.twr.addr = st_ff.tr_base | {11'h0, st_ff.tr_ofs};
            if (ofs_next != buf_size)
               nxt_st.tr_ofs = ofs_next;
            else if (st_ff.tr_ctrl[`CBT_TC_BM_HI:`CBT_TC_BM_LO] == `CBT_BM_CIRC)
               nxt_st.tr_ofs = 21'h0; // [R23]
            else
            begin
               // Simple buffer: stop, flag full, raise exception now [R6] [R22]
               nxt_st.tr_ofs              = 21'h0;
               nxt_st.tr_ctrl[`CBT_TC_EN]   = 1'b0;
               nxt_st.tr_ctrl[`CBT_TC_FULL] = 1'b1; // [R21]
               nxt_st.exc.valid           = 1'b1;
               nxt_st.exc.ctx             = st_ff.trig_ctx; // [R8]
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !st_ff.ack;
   assign avs_readdata_out    = st_ff.rdata;
   assign trace_wr_out        = st_ff.twr;
   assign exc_out             = st_ff.exc;
   assign trace_en_out        = st_ff.tr_ctrl[`CBT_TC_EN];
   assign trace_full_out      = st_ff.tr_ctrl[`CBT_TC_FULL];

endmodule : cbt_trigger

// ---- cbt_trigger_props.sv ----
// Port-level checks of the chained breakpoint trace trigger
`timescale 1ns/1ps
module cbt_trigger_props (
   input wire logic               clk_sys_in,
   input wire logic               rst_b_in,
   input wire logic               avs_read_in,
   input wire logic               avs_write_in,
   input wire logic [2:0]         avs_ctx_in,
   input wire logic               avs_waitrequest_out,
   input wire cbt_pkg::cbt_acc_t  acc_in,
   input wire cbt_pkg::cbt_flow_t flow_in,
   input wire cbt_pkg::cbt_csw_t  csw_in,
   input wire logic               sw_breakpoint_instruction_in,
   input wire cbt_pkg::cbt_twr_t  trace_wr_out,
   input wire cbt_pkg::cbt_exc_t  exc_out,
   input wire logic               trace_en_out,
   input wire logic               trace_full_out
);
   import cbt_pkg::*;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);
   a_exc_vector: assert property (exc_out.valid |-> exc_out.vector == 8'h0C)
      else $error("exception vector wrong");
   a_full_with_exc: assert property ($rose(trace_full_out) |->
      exc_out.valid && trace_wr_out.valid && !trace_en_out)
      else $error("fill without exception or stop");
   a_full_no_en: assert property (trace_full_out |-> !trace_en_out)
      else $error("trace enabled while full");
   a_wr_needs_en: assert property (!trace_en_out |=> !trace_wr_out.valid)
      else $error("trace write while disabled");
   a_en_cause: assert property ($rose(trace_en_out) |->
      $past(acc_in.valid) || $past(avs_write_in))
      else $error("trace enable without cause");
   a_full_cause: assert property ($rose(trace_full_out) |-> $past(trace_en_out))
      else $error("full set while idle");
   a_full_clear: assert property ($fell(trace_full_out) |->
      $past(avs_write_in) && $past(avs_ctx_in) == 3'h0)
      else $error("full cleared without master write");
   a_exc_cause: assert property (exc_out.valid |-> $past(acc_in.valid ||
      sw_breakpoint_instruction_in || flow_in.valid || csw_in.valid))
      else $error("exception without event");
   a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("bus answer late");
   a_wait_idle: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
      else $error("waitrequest while idle");
endmodule : cbt_trigger_props

bind cbt_trigger cbt_trigger_props cbt_trigger_props_inst (.clk_sys_in, .rst_b_in,
   .avs_read_in, .avs_write_in, .avs_ctx_in, .avs_waitrequest_out, .acc_in, .flow_in,
   .csw_in, .sw_breakpoint_instruction_in, .trace_wr_out, .exc_out, .trace_en_out,
   .trace_full_out);

// ---- cbt_mem_model.sv ----
// Trace memory and exception sink standing for the CPU side
`timescale 1ns/1ps
module cbt_mem_model (
   input wire logic              clk_sys_in,
   input wire logic              rst_b_in,
   input wire cbt_pkg::cbt_twr_t trace_wr_in,
   input wire cbt_pkg::cbt_exc_t exc_in,
   output int                    wr_count_out,
   output int                    exc_count_out,
   output logic [31:0]           last_addr_out,
   output logic [31:0]           last_data_out,
   output logic [2:0]            exc_ctx_out
);
   import cbt_pkg::*;
   // Memory takes a record every cycle, so no back-pressure exists
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wr_count_out  <= 0;
         exc_count_out <= 0;
         last_addr_out <= 32'h0;
         last_data_out <= 32'h0;
         exc_ctx_out   <= 3'h0;
      end
      else
      begin
         if (trace_wr_in.valid === 1'b1)
         begin
            wr_count_out  <= wr_count_out + 1;
            last_addr_out <= trace_wr_in.addr;
            last_data_out <= trace_wr_in.data;
         end
         if (exc_in.valid === 1'b1)
         begin
            exc_count_out <= exc_count_out + 1;
            exc_ctx_out   <= exc_in.ctx;
         end
      end
   end
endmodule : cbt_mem_model

// ---- chained_breakpoint_trace_trigger_bench.sv ----
// Self-checking bench for the chained breakpoint trace trigger
`timescale 1ns/1ps
module chained_breakpoint_trace_trigger_bench;
   import cbt_pkg::*;
   logic        clk_sys_in, rst_b_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [7:0]  avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, last_addr, last_data, seed, rd;
   logic [2:0]  avs_ctx_in, sw_ctx, exc_ctx;
   logic        sw_brk, trace_en_out, trace_full_out;
   cbt_acc_t    acc_in;
   cbt_flow_t   flow_in;
   cbt_csw_t    csw_in;
   cbt_twr_t    trace_wr_out;
   cbt_exc_t    exc_out;
   int          wr_cnt, exc_cnt, n0, e0;
   int          bad_count = 0;
   int          check_count = 0;

   cbt_trigger cbt_trigger_inst (.clk_sys_in, .rst_b_in, .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF), .avs_ctx_in,
      .avs_readdata_out, .avs_waitrequest_out, .acc_in, .flow_in, .csw_in,
      .sw_breakpoint_instruction_in(sw_brk), .sw_breakpoint_ctx_in(sw_ctx), .trace_wr_out,
      .exc_out, .trace_en_out, .trace_full_out);
   cbt_mem_model cbt_mem_model_inst (.clk_sys_in, .rst_b_in, .trace_wr_in(trace_wr_out),
      .exc_in(exc_out), .wr_count_out(wr_cnt), .exc_count_out(exc_cnt),
      .last_addr_out(last_addr), .last_data_out(last_data), .exc_ctx_out(exc_ctx));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   // Circular and simple buffers both step by one word from the base
   function automatic logic [31:0] exp_addr(input logic [31:0] base, input int i, input int sz);
      return base + 32'((4 * i) % sz);
   endfunction : exp_addr

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [2:0] c);
      @(posedge clk_sys_in);
      avs_address_in   <= a;
      avs_read_in      <= !wr;
      avs_write_in     <= wr;
      avs_writedata_in <= d;
      avs_ctx_in       <= c;
      do
         @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus

   task automatic set_cfg(input int n, input logic [31:0] m, a, d, k);
      bus(1'b1, 8'(n * 16), m, 3'h0);
      bus(1'b1, 8'(n * 16 + 4), a, 3'h0);
      bus(1'b1, 8'(n * 16 + 8), d, 3'h0);
      bus(1'b1, 8'(n * 16 + 12), k, 3'h0);
   endtask : set_cfg

   // Idle access fields keep changing so a stale value never passes for a match
   task automatic access(input logic f, r, w, input logic [2:0] c, input logic [31:0] a, d);
      @(posedge clk_sys_in);
      acc_in <= '{1'b1, f, r, w, c, a, d};
      @(posedge clk_sys_in);
      acc_in <= '{1'b0, 1'b0, 1'b0, 1'b0, 3'h5, ~a, rnd()};
      repeat (3) @(negedge clk_sys_in);
   endtask : access

   task automatic flows(input int n);
      repeat (n)
      begin
         @(posedge clk_sys_in);
         flow_in <= '{1'b1, 1'b1, 1'b0, rnd()};
      end
      @(posedge clk_sys_in);
      flow_in <= '{1'b0, 1'b0, 1'b0, rnd()};
      repeat (3) @(negedge clk_sys_in);
   endtask : flows

   task automatic pulse(input logic is_sw, input logic [2:0] c);
      @(posedge clk_sys_in);
      sw_brk  <= is_sw;
      sw_ctx  <= c;
      csw_in  <= '{!is_sw, c};
      @(posedge clk_sys_in);
      sw_brk  <= 1'b0;
      csw_in  <= '{1'b0, 3'h6};
      repeat (3) @(negedge clk_sys_in);
   endtask : pulse

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      bad_count++;
      summarize();
   end

   initial
   begin
      seed = 32'hAA24D1D4;
      rst_b_in = 1'b0;
      {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in, avs_ctx_in} = '0;
      acc_in = '0;
      flow_in = '0;
      csw_in = '0;
      sw_brk = 1'b0;
      sw_ctx = 3'h0;
      repeat (4) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      bus(1'b0, 8'h70, 32'h0, 3'h0);
      check("mode reset", rd, 32'h0);
      bus(1'b0, 8'h90, 32'h0, 3'h0);
      check("unmapped read", rd, 32'h0);
      e0 = exc_cnt;
      pulse(1'b1, 3'h2);
      check("sw exc ctx", {29'(exc_cnt - e0), exc_ctx}, {29'd1, 3'h2});
      bus(1'b1, 8'h80, 32'h1, 3'h0);
      pulse(1'b1, 3'h3);
      check("sw nop", exc_cnt - e0, 32'd1);
      set_cfg(3, 32'hD190, 32'h1000, rnd(), rnd());
      bus(1'b1, 8'h88, 32'h00020400, 3'h0);
      bus(1'b1, 8'h84, 32'h4485, 3'h0);
      bus(1'b0, 8'h84, 32'h0, 3'h0);
      check("trace ctrl simple", rd, 32'h0485);
      access(1'b1, 1'b1, 1'b0, 3'h2, 32'h1000, rnd());
      check("ctx filter", trace_en_out, 1'b0);
      access(1'b1, 1'b1, 1'b0, 3'h3, 32'h1000, rnd());
      check("trigger enables", trace_en_out, 1'b1);
      n0 = wr_cnt;
      flows(255);
      check("no early exc", exc_cnt - e0, 32'd1);
      flows(2);
      check("fill count", wr_cnt - n0, 32'd256);
      check("last addr", last_addr, exp_addr(32'h00020400, 255, 1024));
      check("fill exc", {29'(exc_cnt - e0), exc_ctx}, {29'd2, 3'h3});
      check("full stop", {trace_full_out, trace_en_out}, 2'b10);
      access(1'b1, 1'b1, 1'b0, 3'h3, 32'h1000, rnd());
      check("full blocks", trace_en_out, 1'b0);
      bus(1'b1, 8'h84, 32'h4485, 3'h0);
      @(negedge clk_sys_in);
      check("full cleared", trace_full_out, 1'b0);
      set_cfg(0, 32'hD130, 32'h1800, rnd(), 32'hFFFFFFFF);
      set_cfg(1, 32'hB172, 32'h2000, 32'h12345678, 32'hFFFFFFFF);
      set_cfg(2, 32'hC052, 32'h2100, 32'h12345678, 32'h0);
      bus(1'b1, 8'h84, 32'h4886, 3'h0);
      repeat (3) access(1'b1, 1'b1, 1'b0, 3'h2, 32'h1800, rnd());
      access(1'b0, 1'b1, 1'b0, 3'h1, 32'h2100, rnd());
      check("order", trace_en_out, 1'b0);
      access(1'b0, 1'b0, 1'b1, 3'h2, 32'h2000, 32'h12345679);
      access(1'b0, 1'b1, 1'b0, 3'h1, 32'h2100, rnd());
      check("exact data", trace_en_out, 1'b0);
      access(1'b0, 1'b0, 1'b1, 3'h2, 32'h2000, 32'h12345678);
      access(1'b0, 1'b1, 1'b0, 3'(rnd() % 5), 32'h2100, rnd());
      check("chain fires", trace_en_out, 1'b1);
      bus(1'b1, 8'h84, 32'h0, 3'h0);
      access(1'b0, 1'b1, 1'b0, 3'h1, 32'h2100, rnd());
      check("progress cleared", trace_en_out, 1'b0);
      set_cfg(5, 32'hD230, 32'h3000, 32'h0, 32'h0);
      set_cfg(6, 32'hB277, 32'h4000, 32'h12345678, 32'hFFFFFFFF);
      set_cfg(7, 32'hD220, 32'h3100, 32'h0, 32'h0);
      e0 = exc_cnt;
      access(1'b1, 1'b1, 1'b0, 3'h4, 32'h3100, rnd());
      check("final alone", exc_cnt - e0, 32'd0);
      access(1'b1, 1'b1, 1'b0, 3'h4, 32'h3000, rnd());
      access(1'b0, 1'b0, 1'b1, 3'h4, 32'h4044, 32'h12345678);
      access(1'b1, 1'b1, 1'b0, 3'h4, 32'h3100, rnd());
      check("chain exc", {29'(exc_cnt - e0), exc_ctx}, {29'd1, 3'h4});
      bus(1'b1, 8'h88, 32'h00010800, 3'h0);
      bus(1'b1, 8'h84, 32'hC446, 3'h0);
      bus(1'b0, 8'h84, 32'h0, 3'h0);
      check("trace ctrl circ", {rd[30:0], trace_en_out}, {31'h8446, 1'b1});
      n0 = wr_cnt;
      flows(512);
      pulse(1'b0, 3'h0);
      check("wrap count", wr_cnt - n0, 32'd513);
      check("wrap addr", last_addr, exp_addr(32'h00010800, 512, 2048));
      check("switch data", last_data, 32'h0);
      bus(1'b1, 8'h84, 32'h8C00, 3'h0);
      rd = rnd();
      access(1'b0, 1'b1, 1'b0, 3'h1, 32'h2100, rd);
      check("data trace", last_data, rd);
      check("single addr", last_addr, 32'h00010800);
      summarize();
   end
endmodule : chained_breakpoint_trace_trigger_bench
